// *** verilog/fsr_top.sv ***
// Suspend/resume, OTP region erase/program/read and two-frame soft reset
//
// Overview of operation
// - Suspend taken only with no suspend flag, busy flag set, array op running.
// - Suspend ignored when a suspend flag is set or busy flag is clear.
// - Accepted suspend sets its flag at once; busy clears within suspend time.
// - Resume taken only with a suspend flag set and busy flag clear.
// - Accepted resume clears flag at once, sets busy within 200 ns.
// - Three OTP regions of 2048 bytes, four pages each, erased separately.
// - OTP erase runs only if select ends right after the last address bit.
// - Valid erase or program frame starts a timed cycle with busy flag high.
// - Write enable latch is cleared during the OTP erase or program cycle.
// - A set lock bit makes its region ignore erase and program.
// - Region address: top byte 0, bit 11 zero, bits 15..12 give region.
// - OTP program frame: opcode, three address bytes, whole data bytes.
// - OTP read: opcode, address, dummy byte, then data on falling edges.
// - OTP read offset increments per byte and wraps from 7ff to 000.
// - Accepted reset aborts work and clears latch, suspend and OTP cycle.
// - Reset is an enable frame then a reset frame, taken even in suspend.
// - No command but OTP read is taken during the reset latency.
// - Suspend honoured only during array program or erase.
// - Program suspend refuses OTP erase/program; erase suspend refuses erase.
`timescale 1ns/1ps
`default_nettype none
`include "fsr_defs.svh"

module fsr_top
  import fsr_pkg::*;
#(
  parameter int unsigned OTP_ERASE_CYC = `FSR_OTP_ERASE_CYC,
  parameter int unsigned OTP_PROG_CYC  = `FSR_OTP_PROG_CYC,
  parameter int unsigned REGION_BYTES  = 2048,
  parameter int unsigned REGIONS       = 3
)
(
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        spi_clk_in,
  input  wire logic        select_n_in,
  input  wire logic        serial_in_in,
  output logic             serial_out_out,
  output logic             serial_out_oe_out,
  input  wire logic        four_byte_addr_mode_in,
  input  wire logic        write_enable_latch_in,
  input  wire logic [2:0]  otp_lock_bits_in,
  input  wire logic        main_prog_busy_in,
  input  wire logic        main_erase_busy_in,
  output fsr_status_t      status_out,
  output logic             wel_clear_out,
  output logic             soft_reset_out,
  output logic             array_hold_out,
  output logic             array_abort_out,
  output logic             otp_busy_out
);

  localparam int unsigned MEM_BYTES = REGION_BYTES * REGIONS;

  logic [7:0]  mem_r [MEM_BYTES];
  fsr_link_t   l_r;
  fsr_link_t   l_nxt;
  fsr_sys_t    s_r;
  fsr_sys_t    s_nxt;
  logic        so_r;
  logic        oe_r;
  logic        frame_end;
  logic        byte_ev;
  logic        sus_acc;
  logic        res_acc;
  logic        otp_start;
  logic        rst_acc;
  logic        wr_en;
  logic        er_en;
  logic [1:0]  fr_reg;

  // Region number 1..3, or 0 when the address names no region
  function automatic logic [1:0] fsr_region(input logic [31:0] a);
    if (a[31:16] == `FSR_ADDR_TOP && !a[11] &&
        a[15:12] >= `FSR_REGION_LO && a[15:12] <= `FSR_REGION_HI)
      return a[13:12];
    return 2'h0;
  endfunction : fsr_region

  function automatic int unsigned fsr_index(input logic [1:0] r,
                                            input logic [10:0] off);
    return (int'(r) - 1) * REGION_BYTES + int'(off);
  endfunction : fsr_index

  function automatic logic [11:0] fsr_addr_bits(input logic [7:0] op,
                                                input logic four_byte_addr_mode);
    if (op == `FSR_OP_OTP_PROG || !four_byte_addr_mode)
      return `FSR_ADDR3_BITS;
    return `FSR_ADDR4_BITS;
  endfunction : fsr_addr_bits

  // Link side: shift in opcode, address and data on rising serial clock
  logic [11:0] l_aw;
  logic [11:0] l_hdr;
  logic [10:0] l_ridx;
  logic [1:0]  l_reg;

  always_comb
  begin
    l_nxt = l_r;
    l_aw = fsr_addr_bits(l_r.opc, l_r.ads2);
    l_hdr = `FSR_OPC_BITS + l_aw + `FSR_DUMMY_BITS;
    l_reg = fsr_region(l_r.addr);
    l_ridx = l_r.roff;
    l_nxt.ads1 = four_byte_addr_mode_in;
    l_nxt.ads2 = l_r.ads1;
    l_nxt.sh = {l_r.sh[6:0], serial_in_in};
    if (l_r.cnt != `FSR_LEN_MAX)
      l_nxt.cnt = l_r.cnt + 12'h001;
    l_nxt.len = l_nxt.cnt;
    if (l_r.cnt == 12'h000)
    begin
      l_nxt.fc = ~l_r.fc;
      l_nxt.addr = '0;
    end
    if (l_nxt.cnt == `FSR_OPC_BITS)
      l_nxt.opc = l_nxt.sh;
    if (l_r.cnt >= `FSR_OPC_BITS && l_r.cnt < `FSR_OPC_BITS + l_aw)
      l_nxt.addr = {l_r.addr[30:0], serial_in_in};
    if (l_r.opc == `FSR_OP_OTP_PROG && l_nxt.cnt[2:0] == 3'h0 &&
        l_nxt.cnt >= `FSR_OPC_BITS + `FSR_ADDR3_BITS + 12'h008)
    begin
      l_nxt.dat = l_nxt.sh;
      l_nxt.dtog = ~l_r.dtog;
    end
    l_nxt.osh = {l_r.osh[6:0], 1'b0};
    if (l_r.opc == `FSR_OP_OTP_READ && l_nxt.cnt >= l_hdr &&
        l_nxt.cnt[2:0] == l_hdr[2:0])
    begin
      if (l_nxt.cnt == l_hdr)
        l_ridx = l_r.addr[10:0];
      l_nxt.roff = l_ridx + 11'h001;
      l_nxt.osh = (l_reg != 2'h0) ? mem_r[fsr_index(l_reg, l_ridx)]
                                  : 8'hff;
    end
  end

  // Frame counter restarts while select is high; captured fields are kept.
  // System reset clears the link side too, so the frame and byte toggles
  // start from a known level; select is high then, so no link edge races it.
  always_ff @(posedge spi_clk_in or posedge select_n_in or
              negedge reset_n_in)
  begin
    if (!reset_n_in)
      l_r <= '0;
    else if (select_n_in)
      l_r.cnt <= 12'h000;
    else
      l_r <= l_nxt;
  end

  // Read data leaves on falling edges; released whenever select is high
  always_ff @(negedge spi_clk_in or posedge select_n_in or
              negedge reset_n_in)
  begin
    if (!reset_n_in || select_n_in)
    begin
      so_r <= 1'b0;
      oe_r <= 1'b0;
    end
    else
    begin
      so_r <= l_r.osh[7];
      oe_r <= (l_r.opc == `FSR_OP_OTP_READ && l_r.cnt >= l_hdr);
    end
  end

  // System side: decode finished frames, run timers, own the flags
  logic [7:0]  f_op;
  logic [11:0] f_len;
  logic        main_busy;
  logic        otp_ok;

  always_comb
  begin
    s_nxt = s_r;
    f_op = l_r.opc;
    f_len = l_r.len;
    fr_reg = fsr_region(l_r.addr);
    main_busy = main_prog_busy_in | main_erase_busy_in;
    sus_acc = 1'b0;
    res_acc = 1'b0;
    otp_start = 1'b0;
    rst_acc = 1'b0;
    wr_en = 1'b0;
    er_en = 1'b0;
    otp_ok = write_enable_latch_in && fr_reg != 2'h0 &&
             !otp_lock_bits_in[fr_reg - 2'h1] && !s_r.st.write_in_progress_flag &&
             !s_r.otp_busy && !s_r.st.sus[0];
    s_nxt.sel1 = select_n_in;
    s_nxt.sel2 = s_r.sel1;
    s_nxt.sel3 = s_r.sel2;
    s_nxt.tg1 = l_r.dtog;
    s_nxt.tg2 = s_r.tg1;
    s_nxt.tg3 = s_r.tg2;
    frame_end = s_r.sel2 && !s_r.sel3 && (l_r.fc != s_r.fc_seen);
    byte_ev = s_r.tg2 ^ s_r.tg3;
    s_nxt.wel_clr = 1'b0;
    s_nxt.sreset = 1'b0;
    s_nxt.abort = 1'b0;
    if (s_r.rst_cnt != 13'h0000)
      s_nxt.rst_cnt = s_r.rst_cnt - 13'h0001;
    if (s_r.wclr != 12'h000)
      s_nxt.wclr = s_r.wclr - 12'h001;
    if (s_r.sel2 && !s_r.sel3)
    begin
      s_nxt.fc_seen = l_r.fc;
      s_nxt.in_prog = 1'b0;
    end
    // Program bytes are stored as they arrive; cells only lose ones
    if (byte_ev && !s_r.in_prog)
    begin
      s_nxt.in_prog = 1'b1;
      s_nxt.prog_ok = otp_ok && s_r.rst_cnt == 13'h0000;
      s_nxt.prog_off = l_r.addr[10:0];
    end
    if (byte_ev && (s_r.in_prog ? s_r.prog_ok : s_nxt.prog_ok))
    begin
      wr_en = 1'b1;
      s_nxt.prog_off[8:0] = s_nxt.prog_off[8:0] + 9'h001;
    end
    if (frame_end)
    begin
      s_nxt.rst_en = 1'b0;
      if (s_r.rst_cnt == 13'h0000)
      begin
        if (f_op == `FSR_OP_RST_EN && f_len == `FSR_OPC_BITS)
          s_nxt.rst_en = 1'b1;
        if (f_op == `FSR_OP_RST && f_len == `FSR_OPC_BITS && s_r.rst_en)
          rst_acc = 1'b1;
        if (f_op == `FSR_OP_SUSPEND && f_len == `FSR_OPC_BITS &&
            s_r.st.sus == 2'b00 && s_r.st.write_in_progress_flag && main_busy &&
            !s_r.otp_busy)
        begin
          sus_acc = 1'b1;
          s_nxt.st.sus = {main_erase_busy_in, main_prog_busy_in};
          s_nxt.hold = 1'b1;
          s_nxt.wclr = 12'(`FSR_SUS_CYC);
        end
        if (f_op == `FSR_OP_RESUME && f_len == `FSR_OPC_BITS &&
            s_r.st.sus != 2'b00 && !s_r.st.write_in_progress_flag)
        begin
          res_acc = 1'b1;
          s_nxt.st.sus = 2'b00;
          s_nxt.hold = 1'b0;
        end
        if (f_op == `FSR_OP_OTP_ERASE && otp_ok && !s_r.st.sus[1] &&
            f_len == `FSR_OPC_BITS + fsr_addr_bits(f_op, l_r.ads2))
        begin
          otp_start = 1'b1;
          s_nxt.otp_erase = 1'b1;
          s_nxt.timer = 20'(OTP_ERASE_CYC);
        end
        if (f_op == `FSR_OP_OTP_PROG && otp_ok && s_r.prog_ok &&
            f_len[2:0] == 3'h0 &&
            f_len >= `FSR_OPC_BITS + `FSR_ADDR3_BITS + 12'h008)
        begin
          otp_start = 1'b1;
          s_nxt.otp_erase = 1'b0;
          s_nxt.timer = 20'(OTP_PROG_CYC);
        end
        if (otp_start)
        begin
          s_nxt.otp_busy = 1'b1;
          s_nxt.otp_reg = fr_reg;
          s_nxt.wel_clr = 1'b1;
        end
      end
    end
    if (s_r.otp_busy)
    begin
      s_nxt.timer = s_r.timer - 20'h00001;
      if (s_r.timer == 20'h00001)
      begin
        s_nxt.otp_busy = 1'b0;
        er_en = s_r.otp_erase;
      end
    end
    if (rst_acc)
    begin
      s_nxt.sreset = 1'b1;
      s_nxt.abort = 1'b1;
      s_nxt.wel_clr = 1'b1;
      s_nxt.st.sus = 2'b00;
      s_nxt.hold = 1'b0;
      s_nxt.wclr = 12'h000;
      s_nxt.otp_busy = 1'b0;
      s_nxt.timer = 20'h00000;
      er_en = 1'b0;
      s_nxt.rst_cnt = 13'(`FSR_RST_CYC);
    end
    s_nxt.st.write_in_progress_flag = s_nxt.otp_busy | (main_busy & ~s_nxt.hold & ~rst_acc) |
                   (s_nxt.hold & (s_nxt.wclr != 12'h000));
    if (!reset_n_in)
    begin
      s_nxt = '0;
      s_nxt.sel1 = 1'b1;
      s_nxt.sel2 = 1'b1;
      s_nxt.sel3 = 1'b1;
      s_nxt.fc_seen = l_r.fc;
      s_nxt.tg1 = l_r.dtog;
      s_nxt.tg2 = l_r.dtog;
      s_nxt.tg3 = l_r.dtog;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    s_r <= s_nxt;
  end

  // Region cells: program clears bits, erase sets the region to ones
  always_ff @(posedge sys_clk_in)
  begin
    if (wr_en)
      mem_r[fsr_index(fr_reg,
                      s_r.in_prog ? s_r.prog_off : l_r.addr[10:0])] <=
        mem_r[fsr_index(fr_reg,
                        s_r.in_prog ? s_r.prog_off : l_r.addr[10:0])] &
        l_r.dat;
    if (er_en)
      for (int unsigned i = 0; i < REGION_BYTES; i++)
        mem_r[fsr_index(s_r.otp_reg, 11'(i))] <= 8'hff;
  end

  assign serial_out_out    = so_r;
  assign serial_out_oe_out = oe_r;
  assign status_out        = s_r.st;
  assign wel_clear_out     = s_r.wel_clr;
  assign soft_reset_out    = s_r.sreset;
  assign array_hold_out    = s_r.hold;
  assign array_abort_out   = s_r.abort;
  assign otp_busy_out      = s_r.otp_busy;

  property p_sus_set;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      sus_acc |=> (s_r.st.sus != 2'b00) && s_r.hold;
  endproperty
  a_sus_set: assert property (p_sus_set)
    else $error("suspend flag not set after accepted suspend");

  property p_sus_ignore;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (frame_end && l_r.opc == `FSR_OP_SUSPEND &&
       (s_r.st.sus != 2'b00 || !s_r.st.write_in_progress_flag)) |-> !sus_acc;
  endproperty
  a_sus_ignore: assert property (p_sus_ignore)
    else $error("suspend accepted when it must be ignored");

  property p_wip_cleared;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (s_r.hold && s_r.wclr == 12'h000 && !s_r.otp_busy) |-> !s_r.st.write_in_progress_flag;
  endproperty
  a_wip_cleared: assert property (p_wip_cleared)
    else $error("busy flag still set after suspend latency");

  property p_resume;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (res_acc && main_busy) |=> (s_r.st.sus == 2'b00) ##[0:19] s_r.st.write_in_progress_flag;
  endproperty
  a_resume: assert property (p_resume)
    else $error("resume did not clear suspend or raise busy in time");

  property p_otp_start;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      otp_start |=> s_r.st.write_in_progress_flag && wel_clear_out && otp_busy_out;
  endproperty
  a_otp_start: assert property (p_otp_start)
    else $error("OTP cycle start did not set busy and clear latch");

  property p_locked;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (fr_reg != 2'h0 && otp_lock_bits_in[fr_reg - 2'h1]) |-> !otp_start;
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked region accepted erase or program");

  property p_rst_reject;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      (s_r.rst_cnt != 13'h0000) |-> !(otp_start || sus_acc || res_acc);
  endproperty
  a_rst_reject: assert property (p_rst_reject)
    else $error("command taken during reset latency");

  property p_rst_clear;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      rst_acc |-> s_r.rst_en ##1 (s_r.st.sus == 2'b00 && !s_r.otp_busy &&
                                  soft_reset_out);
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("reset without enable frame or state not cleared");

  property p_prog_sus;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      s_r.st.sus[0] |-> !otp_start;
  endproperty
  a_prog_sus: assert property (p_prog_sus)
    else $error("OTP operation started during program suspend");

endmodule : fsr_top
`default_nettype wire

// *** verilog/fsr_defs.svh ***
// Opcodes, address fields and timing counts of the suspend, OTP and reset logic
`ifndef FSR_DEFS_SVH
`define FSR_DEFS_SVH

`define FSR_OP_SUSPEND      8'h75
`define FSR_OP_RESUME       8'h7a
`define FSR_OP_OTP_ERASE    8'h44
`define FSR_OP_OTP_PROG     8'h42
`define FSR_OP_OTP_READ     8'h48
`define FSR_OP_RST_EN       8'h66
`define FSR_OP_RST          8'h99

`define FSR_OPC_BITS        12'h008
`define FSR_ADDR3_BITS      12'h018
`define FSR_ADDR4_BITS      12'h020
`define FSR_DUMMY_BITS      12'h008
`define FSR_LEN_MAX         12'hfff

`define FSR_ADDR_TOP        16'h0000
`define FSR_REGION_LO       4'h1
`define FSR_REGION_HI       4'h3
`define FSR_OFF_BITS        11
`define FSR_PAGE_BITS       9

`define FSR_CLK_MHZ         100
`define FSR_RESUME_NS       200
`define FSR_RESUME_CYC      ((`FSR_RESUME_NS * `FSR_CLK_MHZ) / 1000)
`define FSR_SUS_NS          20000
`define FSR_SUS_CYC         ((`FSR_SUS_NS * `FSR_CLK_MHZ) / 1000)
`define FSR_RST_NS          30000
`define FSR_RST_CYC         ((`FSR_RST_NS * `FSR_CLK_MHZ + 999) / 1000)
`define FSR_OTP_ERASE_CYC   50000
`define FSR_OTP_PROG_CYC    5000

`endif

// *** verilog/fsr_pkg.sv ***
// Types shared by the suspend, OTP and reset command logic
package fsr_pkg;

  typedef struct packed {
    logic       write_in_progress_flag;
    logic [1:0] sus;     // [0] program suspended, [1] erase suspended
  } fsr_status_t;

  typedef struct packed {
    logic [11:0] cnt;
    logic [11:0] len;
    logic [7:0]  sh;
    logic [7:0]  opc;
    logic [31:0] addr;
    logic [7:0]  dat;
    logic        dtog;
    logic        fc;
    logic [10:0] roff;
    logic [7:0]  osh;
    logic        ads1;
    logic        ads2;
  } fsr_link_t;

  typedef struct packed {
    logic        sel1;
    logic        sel2;
    logic        sel3;
    logic        tg1;
    logic        tg2;
    logic        tg3;
    logic        fc_seen;
    fsr_status_t st;
    logic        hold;
    logic [11:0] wclr;
    logic        otp_busy;
    logic        otp_erase;
    logic [1:0]  otp_reg;
    logic [19:0] timer;
    logic        rst_en;
    logic [12:0] rst_cnt;
    logic        wel_clr;
    logic        sreset;
    logic        abort;
    logic        in_prog;
    logic        prog_ok;
    logic [10:0] prog_off;
  } fsr_sys_t;

endpackage : fsr_pkg

// *** testbench/fsr_host.sv ***
// SPI host model that sends command frames to the flash command block
`timescale 1ns/1ps
`default_nettype none

module fsr_host
(
  output logic      spi_clk_out,
  output logic      select_n_out,
  output logic      serial_data_out,
  input  wire logic serial_out_in,
  input  wire logic serial_oe_in
);
  localparam time HALF = 16ns;

  initial
  begin
    spi_clk_out     = 1'b0;
    select_n_out    = 1'b1;
    serial_data_out = 1'b1;
  end

  // Bits leave MSB first; select rises right after the last bit
  task automatic frame(input logic [63:0] tx, input int ntx,
                       input int nrx, output logic [23:0] rx);
    rx = 24'h000000;
    select_n_out = 1'b0;
    #HALF;
    for (int i = 0; i < ntx; i++)
    begin
      serial_data_out = tx[63-i];
      #HALF spi_clk_out = 1'b1;
      #HALF spi_clk_out = 1'b0;
    end
    for (int i = 0; i < nrx; i++)
    begin
      serial_data_out = ~serial_data_out;
      #HALF spi_clk_out = 1'b1;
      rx = {rx[22:0], serial_oe_in ? serial_out_in : 1'bx};
      #HALF spi_clk_out = 1'b0;
    end
    #HALF select_n_out = 1'b1;
    serial_data_out = ~serial_data_out;
    #80ns;
  endtask : frame
endmodule : fsr_host
`default_nettype wire

// *** testbench/fsr_top_test.sv ***
// Self-checking bench for the suspend, OTP and soft reset command block
`timescale 1ns/1ps
`default_nettype none

module fsr_top_test
  import fsr_pkg::*;
;
  logic        sys_clk_in = 1'b0;
  logic        reset_n_in = 1'b1;
  logic        prog_busy  = 1'b0;
  logic        erase_busy = 1'b0;
  logic        write_enable_latch        = 1'b0;
  logic        four_byte_addr_mode        = 1'b0;
  logic [2:0]  lock       = 3'h0;
  logic [23:0] rx;
  wire logic   spi_clk, select_n, sdi, sdo, sdo_oe;
  fsr_status_t status;
  logic        wel_clr, soft_rst, hold, abort, otp_busy;
  int          fail_count = 0;
  int          n_tests    = 0;
  int          n_wclr = 0, n_srst = 0, n_abort = 0;

  always #5 sys_clk_in = ~sys_clk_in;

  // Pulse counters; the latch drops when the block asks it to
  always @(posedge sys_clk_in)
  begin
    if (wel_clr === 1'b1)
    begin
      n_wclr++;
      write_enable_latch <= 1'b0;
    end
    if (soft_rst === 1'b1) n_srst++;
    if (abort === 1'b1) n_abort++;
  end

  fsr_top #(.OTP_ERASE_CYC(20), .OTP_PROG_CYC(20)) dut
  (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .spi_clk_in(spi_clk), .select_n_in(select_n), .serial_in_in(sdi),
    .serial_out_out(sdo), .serial_out_oe_out(sdo_oe),
    .four_byte_addr_mode_in(four_byte_addr_mode), .write_enable_latch_in(write_enable_latch),
    .otp_lock_bits_in(lock), .main_prog_busy_in(prog_busy),
    .main_erase_busy_in(erase_busy), .status_out(status),
    .wel_clear_out(wel_clr), .soft_reset_out(soft_rst),
    .array_hold_out(hold), .array_abort_out(abort),
    .otp_busy_out(otp_busy)
  );

  fsr_host host
  (
    .spi_clk_out(spi_clk), .select_n_out(select_n),
    .serial_data_out(sdi), .serial_out_in(sdo), .serial_oe_in(sdo_oe)
  );

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : tick

  // Frame then let the decode land in the system domain
  task automatic send(input logic [63:0] tx, input int ntx);
    host.frame(tx, ntx, 0, rx);
    tick(4);
  endtask : send

  task automatic wait_idle(input int lim);
    int k;
    k = 0;
    while (status.write_in_progress_flag !== 1'b0 && k < lim)
    begin
      tick(1);
      k++;
    end
    if (k >= lim)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, status, 3'h0);
      fail_count++;
      report_and_stop();
    end
  endtask : wait_idle

  task automatic t_suspend();
    send({8'h75, 56'h0}, 8);
    check(status, 3'b000);
    prog_busy = 1'b1;
    tick(3);
    send({8'h75, 56'h0}, 8);
    check(status, 3'b101);
    check(hold, 1'b1);
    send({8'h75, 56'h0}, 8);
    check(status, 3'b101);
    send({8'h7a, 56'h0}, 8);
    check(status, 3'b101);
    wait_idle(2100);
    check(status, 3'b001);
    write_enable_latch = 1'b1;
    send({8'h44, 24'h001000, 32'h0}, 32);
    check(otp_busy, 1'b0);
    send({8'h42, 24'h001000, 8'h00, 24'h0}, 40);
    check(otp_busy, 1'b0);
    send({8'h7a, 56'h0}, 8);
    check(status, 3'b100);
    check(hold, 1'b0);
    send({8'h7a, 56'h0}, 8);
    check(status, 3'b100);
    prog_busy = 1'b0;
    write_enable_latch = 1'b0;
    tick(3);
    $display("suspend and resume test done");
  endtask : t_suspend

  task automatic t_otp();
    int w;
    w = n_wclr;
    write_enable_latch = 1'b1;
    send({8'h44, 24'h001000, 32'h0}, 32);
    check(otp_busy, 1'b1);
    check(status, 3'b100);
    check(n_wclr, w + 1);
    wait_idle(100);
    write_enable_latch = 1'b1;
    send({8'h42, 24'h0017fe, 8'ha5, 8'h3c, 16'h0}, 48);
    check(otp_busy, 1'b1);
    wait_idle(100);
    host.frame({8'h48, 24'h0017fe, 8'h00, 24'h0}, 40, 24, rx);
    check(rx, 24'ha53cff);
    write_enable_latch = 1'b1;
    lock = 3'b001;
    send({8'h44, 24'h001000, 32'h0}, 32);
    check(otp_busy, 1'b0);
    lock = 3'b000;
    send({8'h44, 24'h001000, 32'h0}, 33);
    check(otp_busy, 1'b0);
    send({8'h44, 24'h004000, 32'h0}, 32);
    check(otp_busy, 1'b0);
    four_byte_addr_mode = 1'b1;
    tick(3);
    send({8'h44, 32'h00002000, 24'h0}, 40);
    check(otp_busy, 1'b1);
    wait_idle(100);
    four_byte_addr_mode = 1'b0;
    $display("security region test done");
  endtask : t_otp

  task automatic t_reset();
    int s;
    int r;
    s = n_srst;
    send({8'h66, 56'h0}, 8);
    send({8'h75, 56'h0}, 8);
    send({8'h99, 56'h0}, 8);
    check(n_srst, s);
    erase_busy = 1'b1;
    tick(3);
    send({8'h75, 56'h0}, 8);
    check(status.sus, 2'b10);
    s = n_abort;
    r = n_srst;
    send({8'h66, 56'h0}, 8);
    send({8'h99, 56'h0}, 8);
    check(n_abort, s + 1);
    check(n_srst, r + 1);
    check(status.sus, 2'b00);
    erase_busy = 1'b0;
    prog_busy = 1'b1;
    tick(3);
    send({8'h75, 56'h0}, 8);
    check(status.sus, 2'b00);
    prog_busy = 1'b0;
    $display("soft reset test done");
  endtask : t_reset

  initial
  begin
    // Falling edge of reset also clears the link side of the block
    #1 reset_n_in = 1'b0;
    tick(4);
    reset_n_in = 1'b1;
    tick(3);
    check(status, 3'b000);
    t_suspend();
    t_otp();
    t_reset();
    report_and_stop();
  end
endmodule : fsr_top_test
`default_nettype wire
